// ---- adcp_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the ADC link.
// Assumes: hclk at 200 MHz; converter oscillator nominally 32768 Hz.
// Notes: Definitions only.
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

// ****************************************
// Command byte fields
// ****************************************
`define ADCP_CMD_START 7
`define ADCP_CMD_MODE50 6
`define ADCP_CMD_SLEEP 5
`define ADCP_CMD_ZERO 4
`define ADCP_CMD_SEL_LOW 2
`define ADCP_CMD_SEL_HIGH 1
`define ADCP_CMD_RESET 8'h00

// ****************************************
// Select codes, written {select_bit_high, select_bit_low}
// ****************************************
`define ADCP_SEL_LOW_BYTE 2'h0
`define ADCP_SEL_HIGH_BYTE 2'h1
`define ADCP_SEL_STATUS 2'h2
`define ADCP_SEL_INVALID 2'h3
`define ADCP_INVALID_DATA 8'h00

// ****************************************
// Converter timing, in oscillator counts
// ****************************************
`define ADCP_CONV_COUNTS 11'h71c
`define ADCP_INT60_COUNTS 11'h222
`define ADCP_INT50_COUNTS 11'h28f
`define ADCP_CLK_HZ 200000000
`define ADCP_OSC_HZ 32768
`define ADCP_OSC_DIV (`ADCP_CLK_HZ / `ADCP_OSC_HZ)

// ****************************************
// Host link strobe timing, in hclk cycles
// ****************************************
`define ADCP_SETUP_CYC 8'h04
`define ADCP_STROBE_CYC 8'h08
`define ADCP_HOLD_CYC 8'h04

// ****************************************
// Host register offsets (byte addresses)
// ****************************************
`define ADCP_REG_CMD 4'h0
`define ADCP_REG_READ 4'h4
`define ADCP_REG_STAT 4'h8
`define ADCP_STAT_BUSY 0
`define ADCP_STAT_EOC 1

`endif

// ---- adcp_pkg.sv ----
// Purpose: Types shared by both ends of the ADC link.
// Assumes: Constants come from adcp_consts.svh.
// Notes: Each end of the link keeps all its state in one of these structs.
package adcp_pkg;

  // ****************************************
  // Converter phase and host link states
  // ****************************************
  typedef enum logic [1:0] {
    ADCP_PH_IDLE = 2'b00,
    ADCP_PH_RUN = 2'b01,
    ADCP_PH_SLEEP = 2'b10
  } adcp_phase_type;

  typedef enum logic [1:0] {
    ADCP_LK_IDLE = 2'b00,
    ADCP_LK_SETUP = 2'b01,
    ADCP_LK_STROBE = 2'b10,
    ADCP_LK_HOLD = 2'b11
  } adcp_link_type;

  // ****************************************
  // Device end state
  // ****************************************
  typedef struct packed {
    logic cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2, wr_prev, rd_prev;
    logic [7:0] d_s1, d_s2;
    logic [7:0] cmd;
    logic start_pend;
    logic zero_run;
    adcp_phase_type phase;
    logic [15:0] div;
    logic [10:0] cnt;
    logic [17:0] result;
    logic collision;
    logic eoc;
    logic integ;
    logic rd_oe;
    logic [7:0] rd_data;
  } adcp_dev_state_type;

  // ****************************************
  // Host end state
  // ****************************************
  typedef struct packed {
    logic ap_valid, ap_write;
    logic [3:0] ap_addr;
    logic [31:0] hrdata;
    adcp_link_type link;
    logic [7:0] timer;
    logic is_read;
    logic [7:0] dout;
    logic cs_n, rd_n, wr_n, oe;
    logic [7:0] rbyte;
    logic eoc_s1, eoc_s2;
    logic [7:0] d_s1, d_s2;
  } adcp_host_state_type;

endpackage

// ---- adcp_bus_if.sv ----
// Purpose: Carrier for the 8-bit parallel link between host and converter.
// Assumes: Both ends run on hclk.
// Notes: The shared data wire is resolved here from the two drive enables.
`timescale 1ns/1ps
`default_nettype none
interface adcp_bus_if;
  // Strobes, all active low, driven by the host.
  logic cs_n;
  logic rd_n;
  logic wr_n;
  // End of conversion pin, driven by the device.
  logic eoc;
  // Per-end drive of the data bus.
  logic [7:0] dev_dout;
  logic dev_oe;
  logic [7:0] host_dout;
  logic host_oe;
  // Resolved bus level; an undriven bus floats high through a pull-up.
  logic [7:0] data;
  assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hff);

  modport device (input cs_n, rd_n, wr_n, data, output eoc, dev_dout, dev_oe);
  modport host (input eoc, data, output cs_n, rd_n, wr_n, host_dout, host_oe);
endinterface
`default_nettype wire

// ---- adcp_device.sv ----
// Purpose: Converter end of the ADC link: command byte, result and status reads.
// Assumes: Strobes and data arrive unsynchronised; analogue levels arrive as hclk words.
// Notes: Both ends share hclk; the conversion itself is modelled by a counter.
// Functional notes
// - Eight data lines, select, read, write strobes
// - Ignore strobes unless chip select asserted
// - Write strobe captures bus byte into command
// - Host writes select code before reading
// - Drive selected register while read low
// - Release data lines while read high
// - Select in D1 high, D2 low
// - Code 00 low byte, 11 invalid
// - Code 01 high byte, D7 polarity
// - Code 10 status layout, D3 zero
// - Read zero shorts inputs for conversion
// - Otherwise measure positive minus negative input
// - Host subtracts averaged offset results
// - Sleep entered only at end of conversion
// - Sleep stops oscillator, reads still work
// - Host wakes, waits a cycle, then starts
// - D6 low integrates 546 counts
// - D6 high integrates 655 counts
// - Host initialises device after power-up
// - Start bit begins one conversion, self-clears
// - End pin mirrors end-of-conversion status
// - Status read clears collision flag
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_consts.svh"
module adcp_device #(
  parameter int OSC_DIV = `ADCP_OSC_DIV,
  parameter logic [10:0] CONV_COUNTS = `ADCP_CONV_COUNTS,
  parameter logic [10:0] INT60_COUNTS = `ADCP_INT60_COUNTS,
  parameter logic [10:0] INT50_COUNTS = `ADCP_INT50_COUNTS
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Link to the host.
  adcp_bus_if.device bus,
  // Analogue levels as signed words with three fractional bits.
  input wire logic [17:0] positive_input,
  input wire logic [17:0] negative_input,
  input wire logic [17:0] offset_level,
  // Converter state for the user side.
  output logic sleeping,
  output logic integrating,
  output logic [7:0] command_word
);

  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

  adcp_pkg::adcp_dev_state_type st_ff;
  adcp_pkg::adcp_dev_state_type nxt_st;

  logic cs_act;
  logic wr_rise;
  logic rd_rise;
  logic [1:0] sel;
  logic osc_tick;
  logic [10:0] int_len;
  logic [17:0] conv_value;
  logic load_result;
  logic status_read_end;
  logic [7:0] status_byte;

  // ****************************************
  // Decode of strobes and command fields
  // ****************************************

  // Only the second synchroniser stage and later flops are looked at.
  assign cs_act = ~st_ff.cs_s2;
  assign wr_rise = cs_act & st_ff.wr_s2 & ~st_ff.wr_prev;
  assign rd_rise = cs_act & st_ff.rd_s2 & ~st_ff.rd_prev;
  assign sel = {st_ff.cmd[`ADCP_CMD_SEL_HIGH], st_ff.cmd[`ADCP_CMD_SEL_LOW]};
  assign int_len = st_ff.cmd[`ADCP_CMD_MODE50] ? INT50_COUNTS : INT60_COUNTS;
  assign osc_tick = (st_ff.phase == adcp_pkg::ADCP_PH_RUN) && (st_ff.div == DIV_LAST);
  assign load_result = osc_tick && (st_ff.cnt == CONV_COUNTS - 11'h001);
  assign status_read_end = rd_rise & (sel == `ADCP_SEL_STATUS);

  // Read-zero shorts the inputs, so only the system offset is converted.
  assign conv_value = st_ff.zero_run ? offset_level
                                     : 18'(positive_input - negative_input + offset_level);

  // Status byte: collision, end, integrating, sleep, a fixed zero, fractions.
  assign status_byte = {st_ff.collision, st_ff.eoc, st_ff.integ,
                        st_ff.phase == adcp_pkg::ADCP_PH_SLEEP, 1'b0,
                        st_ff.result[2:0]};

  // ****************************************
  // Next state
  // ****************************************

  // Fills the full next state from the current state and the pins.
  always_comb begin
    nxt_st = st_ff;
    // Two-flop synchronisers on every pin from the host.
    nxt_st.cs_s1 = bus.cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.rd_s1 = bus.rd_n;
    nxt_st.rd_s2 = st_ff.rd_s1;
    nxt_st.wr_s1 = bus.wr_n;
    nxt_st.wr_s2 = st_ff.wr_s1;
    nxt_st.d_s1 = bus.data;
    nxt_st.d_s2 = st_ff.d_s1;
    nxt_st.wr_prev = st_ff.wr_s2;
    nxt_st.rd_prev = st_ff.rd_s2;

    // Command byte changes on a selected write; its start bit also clears when a conversion begins.
    if (wr_rise) begin
      nxt_st.cmd = st_ff.d_s2;
      if (st_ff.d_s2[`ADCP_CMD_START]) begin
        nxt_st.start_pend = 1'b1;
      end
    end

    // Oscillator divider runs only while converting.
    if (st_ff.phase == adcp_pkg::ADCP_PH_RUN) begin
      nxt_st.div = osc_tick ? 16'h0000 : st_ff.div + 16'h0001;
    end else begin
      nxt_st.div = 16'h0000;
    end

    unique case (st_ff.phase)
      adcp_pkg::ADCP_PH_IDLE: begin
        // Waits at count zero with end of conversion shown.
        if (st_ff.cmd[`ADCP_CMD_SLEEP]) begin
          nxt_st.phase = adcp_pkg::ADCP_PH_SLEEP;
        end else if (st_ff.start_pend) begin
          nxt_st.phase = adcp_pkg::ADCP_PH_RUN;
          nxt_st.cnt = 11'h001;
          nxt_st.start_pend = 1'b0;
          nxt_st.cmd[`ADCP_CMD_START] = 1'b0;
          nxt_st.zero_run = st_ff.cmd[`ADCP_CMD_ZERO];
          nxt_st.eoc = 1'b0;
          nxt_st.integ = 1'b1;
        end
      end
      adcp_pkg::ADCP_PH_RUN: begin
        if (osc_tick) begin
          if (load_result) begin
            nxt_st.cnt = 11'h000;
            nxt_st.phase = adcp_pkg::ADCP_PH_IDLE;
            nxt_st.result = conv_value;
            nxt_st.eoc = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 11'h001;
          end
          // Integration covers counts one through the selected length.
          if (st_ff.cnt == int_len) begin
            nxt_st.integ = 1'b0;
          end
        end
      end
      adcp_pkg::ADCP_PH_SLEEP: begin
        // Oscillator stopped; wakes once the sleep bit is written back to zero.
        if (!st_ff.cmd[`ADCP_CMD_SLEEP]) begin
          nxt_st.phase = adcp_pkg::ADCP_PH_IDLE;
        end
      end
      default: begin
        nxt_st.phase = adcp_pkg::ADCP_PH_IDLE;
      end
    endcase

    // Collision marks a result update during a read; the set wins over the clear.
    if (load_result && st_ff.rd_oe) begin
      nxt_st.collision = 1'b1;
    end else if (status_read_end) begin
      nxt_st.collision = 1'b0;
    end

    // Drive the bus only while chip select and read are both low.
    nxt_st.rd_oe = cs_act & ~st_ff.rd_s2;
    unique case (sel)
      `ADCP_SEL_LOW_BYTE: nxt_st.rd_data = st_ff.result[10:3];
      `ADCP_SEL_HIGH_BYTE: nxt_st.rd_data = {st_ff.result[17], st_ff.result[17:11]};
      `ADCP_SEL_STATUS: nxt_st.rd_data = status_byte;
      `ADCP_SEL_INVALID: nxt_st.rd_data = `ADCP_INVALID_DATA;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************

  // Strobes reset to their idle high level; the converter waits at count zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.rd_s1 <= 1'b1;
      st_ff.rd_s2 <= 1'b1;
      st_ff.wr_s1 <= 1'b1;
      st_ff.wr_s2 <= 1'b1;
      st_ff.wr_prev <= 1'b1;
      st_ff.rd_prev <= 1'b1;
      st_ff.cmd <= `ADCP_CMD_RESET;
      st_ff.phase <= adcp_pkg::ADCP_PH_IDLE;
      st_ff.eoc <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Pin and user-side outputs come straight from flops, except sleeping, which is decoded from the phase.
  assign bus.eoc = st_ff.eoc;
  assign bus.dev_dout = st_ff.rd_data;
  assign bus.dev_oe = st_ff.rd_oe;
  assign sleeping = (st_ff.phase == adcp_pkg::ADCP_PH_SLEEP);
  assign integrating = st_ff.integ;
  assign command_word = st_ff.cmd;

endmodule // adcp_device
`default_nettype wire

// ---- adcp_host.sv ----
// Purpose: Host end: AHB-Lite registers turned into link write and read cycles.
// Assumes: One AHB-Lite master, single word transfers, hready equals hreadyout.
// Notes: Orders given while a cycle runs are dropped; poll the busy bit.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_consts.svh"
module adcp_host (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Link to the converter.
  adcp_bus_if.host bus
);

  adcp_pkg::adcp_host_state_type st_ff;
  adcp_pkg::adcp_host_state_type nxt_st;
  logic busy;
  logic [31:0] stat_word;

  assign busy = (st_ff.link != adcp_pkg::ADCP_LK_IDLE);
  assign stat_word = {16'h0000, st_ff.rbyte, 6'h00, st_ff.eoc_s2, busy};

  // ****************************************
  // Next state
  // ****************************************

  // Bus decode, link sequencing and pin synchronisers.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.eoc_s1 = bus.eoc;
    nxt_st.eoc_s2 = st_ff.eoc_s1;
    nxt_st.d_s1 = bus.data;
    nxt_st.d_s2 = st_ff.d_s1;

    // Address phase is taken when selected, non-idle and ready.
    nxt_st.ap_valid = hsel & htrans[1] & hready;
    nxt_st.ap_write = hwrite;
    nxt_st.ap_addr = haddr[3:0];
    if (hsel & htrans[1] & hready & ~hwrite) begin
      nxt_st.hrdata = (haddr[3:0] == `ADCP_REG_STAT) ? stat_word : 32'h00000000;
    end

    // Data phase write launches a link cycle when the link is free.
    if (st_ff.ap_valid && st_ff.ap_write && !busy) begin
      if (st_ff.ap_addr == `ADCP_REG_CMD) begin
        nxt_st.link = adcp_pkg::ADCP_LK_SETUP;
        nxt_st.is_read = 1'b0;
        nxt_st.dout = hwdata[7:0];
        nxt_st.cs_n = 1'b0;
        nxt_st.oe = 1'b1;
        nxt_st.timer = `ADCP_SETUP_CYC;
      end else if (st_ff.ap_addr == `ADCP_REG_READ) begin
        nxt_st.link = adcp_pkg::ADCP_LK_SETUP;
        nxt_st.is_read = 1'b1;
        nxt_st.cs_n = 1'b0;
        nxt_st.timer = `ADCP_SETUP_CYC;
      end
    end

    unique case (st_ff.link)
      adcp_pkg::ADCP_LK_IDLE: begin
      end
      adcp_pkg::ADCP_LK_SETUP: begin
        nxt_st.timer = st_ff.timer - 8'h01;
        if (st_ff.timer == 8'h01) begin
          nxt_st.link = adcp_pkg::ADCP_LK_STROBE;
          nxt_st.timer = `ADCP_STROBE_CYC;
          nxt_st.rd_n = ~st_ff.is_read;
          nxt_st.wr_n = st_ff.is_read;
        end
      end
      adcp_pkg::ADCP_LK_STROBE: begin
        nxt_st.timer = st_ff.timer - 8'h01;
        if (st_ff.timer == 8'h01) begin
          nxt_st.link = adcp_pkg::ADCP_LK_HOLD;
          nxt_st.timer = `ADCP_HOLD_CYC;
          nxt_st.rd_n = 1'b1;
          nxt_st.wr_n = 1'b1;
          if (st_ff.is_read) begin
            nxt_st.rbyte = st_ff.d_s2;
          end
        end
      end
      adcp_pkg::ADCP_LK_HOLD: begin
        // Data and select stay until well after the strobe has risen.
        nxt_st.timer = st_ff.timer - 8'h01;
        if (st_ff.timer == 8'h01) begin
          nxt_st.link = adcp_pkg::ADCP_LK_IDLE;
          nxt_st.cs_n = 1'b1;
          nxt_st.oe = 1'b0;
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************

  // Strobes reset high and the bus undriven.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.cs_n <= 1'b1;
      st_ff.rd_n <= 1'b1;
      st_ff.wr_n <= 1'b1;
      st_ff.link <= adcp_pkg::ADCP_LK_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.hrdata;
  assign bus.cs_n = st_ff.cs_n;
  assign bus.rd_n = st_ff.rd_n;
  assign bus.wr_n = st_ff.wr_n;
  assign bus.host_dout = st_ff.dout;
  assign bus.host_oe = st_ff.oe;

endmodule // adcp_host
`default_nettype wire

// ---- adcp_link_monitor.sv ----
// Purpose: Watches the parallel link between host and converter ends.
// Assumes: Both ends run on hclk; reset is asynchronous, active low.
// Notes: Figures follow the host strobe timing and device drive delay.
`timescale 1ns/1ps
`default_nettype none
module adcp_link_monitor (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Link signals.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic eoc,
  input wire logic [7:0] dev_dout,
  input wire logic dev_oe,
  input wire logic [7:0] host_dout,
  input wire logic host_oe,
  input wire logic [7:0] data
);
  // ****************************************
  // Link checks
  // ****************************************
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Only one end may drive the shared data lines.
  bus_excl_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the data bus");
  strobe_excl_a: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  // A write strobe is qualified and carries the host byte.
  wr_sel_a: assert property (!wr_n |-> !cs_n && host_oe && data == host_dout)
    else $error("write strobe without select or data");
  wr_len_a: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
    else $error("write strobe length wrong");
  wr_data_a: assert property (!wr_n && !$past(wr_n) |-> $stable(host_dout))
    else $error("write data moved under strobe");
  // The device drives only in answer to a selected read.
  rd_drive_a: assert property ($rose(dev_oe) |-> $past(rd_n, 3) == 1'b0 && $past(cs_n, 3) == 1'b0)
    else $error("device drive without selected read");
  rd_release_a: assert property ($rose(rd_n) |-> dev_oe [*3] ##1 !dev_oe)
    else $error("device drive not released in time");
  idle_float_a: assert property (rd_n [*4] |-> !dev_oe)
    else $error("device drives with read high");
  cs_quiet_a: assert property (cs_n |-> wr_n && rd_n && !host_oe)
    else $error("link activity without select");
  // A started conversion keeps the end pin low for at least eight cycles.
  eoc_low_a: assert property ($fell(eoc) |-> !eoc [*8])
    else $error("end of conversion came back too soon");
endmodule // adcp_link_monitor
`default_nettype wire

// ---- tb_adc_parallel_host_interface.sv ----
// Purpose: Drives the host end over AHB-Lite and judges both ends of the link.
// Assumes: Short oscillator division and counts keep conversions brief.
// Notes: Every wait is cut short by the cycle ceiling.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_consts.svh"
module tb_adc_parallel_host_interface;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int DIV = 2;
  localparam logic [10:0] CONV = 11'h03c;
  localparam logic [10:0] I60 = 11'h005;
  localparam logic [10:0] I50 = 11'h007;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [17:0] positive_input = 18'h00100;
  logic [17:0] negative_input = 18'h00b00;
  logic [17:0] offset_level = 18'h00005;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sleeping;
  logic integrating;
  logic [7:0] command_word;
  logic [7:0] mode = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int integ_cyc = 0;
  int n60;
  int n50;
  adcp_bus_if bus ();
  adcp_host adcp_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(bus.host));
  adcp_device #(.OSC_DIV(DIV), .CONV_COUNTS(CONV), .INT60_COUNTS(I60), .INT50_COUNTS(I50))
    adcp_device_inst (.hclk(hclk), .hresetn(hresetn), .bus(bus.device),
    .positive_input(positive_input), .negative_input(negative_input),
    .offset_level(offset_level), .sleeping(sleeping), .integrating(integrating),
    .command_word(command_word));
  adcp_link_monitor adcp_link_monitor_inst (.hclk(hclk), .hresetn(hresetn), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .eoc(bus.eoc), .dev_dout(bus.dev_dout),
    .dev_oe(bus.dev_oe), .host_dout(bus.host_dout), .host_oe(bus.host_oe), .data(bus.data));

  // Clock generation.
  always #2.5 hclk = ~hclk;

  // Cycle ceiling and integration length counter.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (integrating === 1'b1) begin
      integ_cyc <= integ_cyc + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One AHB-Lite single transfer; the address phase waits for hready.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // Polls the busy bit until the link cycle has finished.
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h8, 32'h0, r);
    while (r[0] !== 1'b0 && n < 200) begin
      ahb(1'b0, 32'h8, 32'h0, r);
      n++;
    end
  endtask

  task automatic link_cmd(input logic [7:0] b);
    logic [31:0] r;
    ahb(1'b1, 32'h0, {24'h0, b}, r);
    wait_idle();
  endtask

  // Selects a register with the current mode bits, then reads it.
  task automatic link_read(input logic [1:0] sel, output logic [7:0] b);
    logic [31:0] r;
    link_cmd(mode | {5'h0, sel[0], sel[1], 1'b0});
    ahb(1'b1, 32'h4, 32'h0, r);
    wait_idle();
    ahb(1'b0, 32'h8, 32'h0, r);
    b = r[15:8];
  endtask

  task automatic wait_eoc();
    logic [31:0] r;
    int n;
    n = 0;
    while (bus.eoc !== 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    // The host passes the end pin through two flops before its status word shows it.
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h8, 32'h0, r);
    check(r[1], 1'b1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Power-up state, then an odd command byte and unmapped accesses.
  task automatic s_cmd();
    logic [31:0] r;
    check({command_word, sleeping, integrating, bus.eoc, bus.cs_n}, 12'h003);
    link_cmd(8'h4f);
    check({command_word[6:4], command_word[2:1]}, 5'h13);
    ahb(1'b1, 32'hc, 32'h80, r);
    ahb(1'b0, 32'hc, 32'h0, r);
    check(r, 32'h0);
    ahb(1'b1, 32'h4, 32'h0, r);
    wait_idle();
    check({command_word[6:4], command_word[2:1], bus.eoc, hresp}, 7'h4e);
  endtask

  // One conversion, then every select code is read back.
  task automatic run_conv(input logic z, input logic m, output int ni);
    logic [17:0] res;
    logic [7:0] b;
    mode = {1'b0, m, 1'b0, z, 4'h0};
    res = z ? offset_level : positive_input - negative_input + offset_level;
    integ_cyc = 0;
    link_cmd(mode | 8'h80);
    check({bus.eoc, command_word[7]}, 2'h0);
    wait_eoc();
    ni = integ_cyc;
    link_read(`ADCP_SEL_LOW_BYTE, b);
    check(b, res[10:3]);
    link_read(`ADCP_SEL_HIGH_BYTE, b);
    check(b, {res[17], res[17:11]});
    link_read(`ADCP_SEL_STATUS, b);
    check(b, {4'h4, 1'b0, res[2:0]});
    link_read(`ADCP_SEL_INVALID, b);
    check(b, `ADCP_INVALID_DATA);
  endtask

  // Reads while the result loads, then two status reads.
  // The third low-byte read has its data lines driven when the result loads.
  task automatic s_collide();
    logic [7:0] b;
    int n;
    mode = 8'h00;
    n = 0;
    link_cmd(8'h80);
    while (bus.eoc !== 1'b1 && n < 50) begin
      link_read(`ADCP_SEL_LOW_BYTE, b);
      n++;
    end
    link_read(`ADCP_SEL_STATUS, b);
    check(b[7], 1'b1);
    link_read(`ADCP_SEL_STATUS, b);
    check(b[7], 1'b0);
  endtask

  // Sleep asked in mid-conversion waits for its end; reads still work.
  task automatic s_sleep();
    logic [7:0] b;
    mode = 8'h00;
    link_cmd(8'h80);
    link_cmd(8'h20);
    check({sleeping, bus.eoc}, 2'h0);
    wait_eoc();
    repeat (4) @(posedge hclk);
    check(sleeping, 1'b1);
    mode = 8'h20;
    link_read(`ADCP_SEL_STATUS, b);
    check(b[6:4], 3'h5);
    mode = 8'h00;
    link_cmd(8'h00);
    check(sleeping, 1'b0);
    repeat (DIV * CONV + 10) @(posedge hclk);
  endtask

  // A reset in mid-conversion returns both ends to their idle state.
  task automatic s_rst2();
    link_cmd(8'h80);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({command_word, bus.eoc, bus.dev_oe, bus.cs_n, sleeping}, 12'h00a);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_cmd();
    run_conv(1'b0, 1'b0, n60);
    run_conv(1'b1, 1'b1, n50);
    check(n50 - n60, (I50 - I60) * DIV);
    s_collide();
    s_sleep();
    s_rst2();
    stop_test();
  end
endmodule // tb_adc_parallel_host_interface
`default_nettype wire
